/* File: port_io_defines.svh */
`ifndef PORT_IO_DEFINES_SVH
`define PORT_IO_DEFINES_SVH

// register byte addresses (low 16 bits)
`define ADDR_PIN_DIRECTION 16'hfeb9
`define ADDR_PIN_LEVEL_READBACK 16'hff59
`define ADDR_OUTPUT_VALUE 16'hff69
`define ADDR_PULLUP_ENABLE 16'hff70
`define ADDR_OPENDRAIN_ENABLE 16'hff77
`define ADDR_STANDBY_CONTROL 16'hff7e

// field positions
`define PORT_FIELD_MSB 3
`define PORT_FIELD_LSB 0
`define STANDBY_OUTPUT_HOLD_BIT 0
`define STANDBY_ENTER_BIT 1

// reset values
`define PORT_RESET 4'h0
`define STANDBY_RESET 2'h0
// value returned for undefined / reserved read bits
`define UNDEF_READ_FILL 8'h00

`endif

/* File: port_io_pkg.sv */
package port_io_pkg;
    typedef enum logic [2:0]
    {
        mode_0 = 3'h0,
        mode_1 = 3'h1,
        mode_2 = 3'h2,
        mode_3 = 3'h3,
        mode_4 = 3'h4,
        mode_5 = 3'h5,
        mode_6 = 3'h6,
        mode_7 = 3'h7
    } op_mode_t;

    typedef enum logic [1:0]
    {
        pin_input = 2'h0,
        pin_general = 2'h1,
        pin_address = 2'h3
    } pin_role_t;
endpackage : port_io_pkg

/* File: pin_sync.sv */
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // raw pins and filtered result
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end
        else
        begin
            stage1_reg <= pin_raw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // a bit changes only when stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_agree
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                    pin_level[i] <= 1'b0;
                else if (stage2_reg[i] == stage3_reg[i])
                    pin_level[i] <= stage3_reg[i];
            end
        end
    endgenerate
endmodule : pin_sync

/* File: four_bit_io_port_addr_mux.sv */
// Notes on behaviour
// R1 - four bidirectional pins on bits three to zero
// R2 - direction register write-only, reads undefined
// R3 - control registers cleared only by power-on reset; code also clears them while hw_standby is high
// R4 - modes 1,2,3,7: direction one drives data
// R5 - modes 4,5: all pins drive address
// R6 - mode 6: direction one drives address
// R7 - standby: address pins hold or float
// R8 - output data register readable and writable
// R9 - upper four bits reserved, writes ignored
// R10 - pin-state register read-only, writes ignored
// R11 - readback gives data or sampled pin
// R12 - readback frozen in manual reset, standby; code still updates it while hw_standby is high
// R13 - pull-up only when input and enabled
// R14 - pull-ups off in modes 4 and 5
// R15 - open-drain bit disables high-side driver
// R16 - open-drain active in modes 1,2,3,7
// R17 - mode is static input, decode combinational
//
// Chosen here: strobed register access.
`include "port_io_defines.svh"

module four_bit_io_port_addr_mux #(
    parameter int PORT_WIDTH = 4
) (
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic rstn,
    // chip state
    input wire port_io_pkg::op_mode_t op_mode,
    input wire logic manual_reset,
    input wire logic hw_standby,
    input wire logic [PORT_WIDTH-1:0] address_out,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic [PORT_WIDTH-1:0] port_pin_in,
    output logic [PORT_WIDTH-1:0] port_pin_out,
    output logic [PORT_WIDTH-1:0] port_pin_oe,
    output logic [PORT_WIDTH-1:0] port_pin_pullup,
    // standby status
    output logic sw_standby_active
);
    import port_io_pkg::*;

    logic [PORT_WIDTH-1:0] pin_direction_reg;
    logic [PORT_WIDTH-1:0] output_value_reg;
    logic [PORT_WIDTH-1:0] pullup_enable_reg;
    logic [PORT_WIDTH-1:0] opendrain_enable_reg;
    logic [PORT_WIDTH-1:0] readback_reg;
    logic standby_output_hold_reg;
    logic standby_enter_reg;
    logic [PORT_WIDTH-1:0] pin_level;
    logic [PORT_WIDTH-1:0] readback_next;
    logic [PORT_WIDTH-1:0] out_next;
    logic [PORT_WIDTH-1:0] oe_next;
    logic [PORT_WIDTH-1:0] pullup_next;
    logic [7:0] rdata_next;
    logic hold_logic;
    logic wr_ok;

    function automatic pin_role_t role_of(input op_mode_t m, input logic dir);
        case (m)
            mode_4, mode_5: role_of = pin_address; // [R5]
            mode_6: role_of = dir ? pin_address : pin_input; // [R6]
            mode_1, mode_2, mode_3, mode_7: role_of = dir ? pin_general : pin_input; // [R4]
            default: role_of = pin_input;
        endcase
    endfunction : role_of

    function automatic logic pullup_mode(input op_mode_t m);
        case (m)
            mode_1, mode_2, mode_3, mode_6, mode_7: pullup_mode = 1'b1;
            default: pullup_mode = 1'b0; // [R14]
        endcase
    endfunction : pullup_mode

    function automatic logic odrain_mode(input op_mode_t m);
        case (m)
            mode_1, mode_2, mode_3, mode_7: odrain_mode = 1'b1; // [R16]
            default: odrain_mode = 1'b0;
        endcase
    endfunction : odrain_mode

    pin_sync #(
        .WIDTH(PORT_WIDTH)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_raw(port_pin_in),
        .pin_level(pin_level)
    );

    // manual reset and software standby freeze the readback state
    assign hold_logic = manual_reset || standby_enter_reg;
    assign wr_ok = reg_write && !manual_reset && !hw_standby;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pin_direction_reg <= `PORT_RESET;
        else if (hw_standby)
            pin_direction_reg <= `PORT_RESET; // [R3]
        else if (wr_ok && reg_addr == `ADDR_PIN_DIRECTION)
            pin_direction_reg <= reg_wdata[`PORT_FIELD_MSB:`PORT_FIELD_LSB]; // [R9]
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            output_value_reg <= `PORT_RESET;
        else if (hw_standby)
            output_value_reg <= `PORT_RESET; // [R3]
        else if (wr_ok && reg_addr == `ADDR_OUTPUT_VALUE)
            output_value_reg <= reg_wdata[`PORT_FIELD_MSB:`PORT_FIELD_LSB]; // [R8]
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pullup_enable_reg <= `PORT_RESET;
        else if (hw_standby)
            pullup_enable_reg <= `PORT_RESET; // [R3]
        else if (wr_ok && reg_addr == `ADDR_PULLUP_ENABLE)
            pullup_enable_reg <= reg_wdata[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            opendrain_enable_reg <= `PORT_RESET;
        else if (hw_standby)
            opendrain_enable_reg <= `PORT_RESET; // [R3]
        else if (wr_ok && reg_addr == `ADDR_OPENDRAIN_ENABLE)
            opendrain_enable_reg <= reg_wdata[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
    end

    // standby control: output hold and standby entry
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            standby_output_hold_reg <= 1'b0;
            standby_enter_reg <= 1'b0;
        end
        else if (hw_standby)
        begin
            standby_output_hold_reg <= 1'b0;
            standby_enter_reg <= 1'b0;
        end
        else if (wr_ok && reg_addr == `ADDR_STANDBY_CONTROL)
        begin
            standby_output_hold_reg <= reg_wdata[`STANDBY_OUTPUT_HOLD_BIT];
            standby_enter_reg <= reg_wdata[`STANDBY_ENTER_BIT];
        end
    end

    // readback: data for outputs, pin level for inputs
    always_comb
    begin
        for (int i = 0; i < PORT_WIDTH; i++)
            readback_next[i] = pin_direction_reg[i] ? output_value_reg[i] : pin_level[i]; // [R11]
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            readback_reg <= `PORT_RESET;
        else if (!hold_logic || hw_standby)
            readback_reg <= readback_next; // [R12]
    end

    // pin drive decode, from static mode and register bits
    always_comb
    begin
        out_next = '0;
        oe_next = '0;
        pullup_next = '0;
        for (int i = 0; i < PORT_WIDTH; i++)
        begin
            case (role_of(op_mode, pin_direction_reg[i])) // [R17]
                pin_general:
                begin
                    out_next[i] = output_value_reg[i];
                    // high side off when open drain
                    oe_next[i] = !(odrain_mode(op_mode) && opendrain_enable_reg[i]
                        && output_value_reg[i]); // [R15]
                end
                pin_address:
                begin
                    if (standby_enter_reg && standby_output_hold_reg)
                    begin
                        out_next[i] = port_pin_out[i]; // [R7]
                        oe_next[i] = 1'b1;
                    end
                    else if (standby_enter_reg)
                    begin
                        out_next[i] = 1'b0; // [R7]
                        oe_next[i] = 1'b0;
                    end
                    else
                    begin
                        out_next[i] = address_out[i];
                        oe_next[i] = 1'b1;
                    end
                end
                default:
                    pullup_next[i] = pullup_mode(op_mode) && pullup_enable_reg[i]; // [R13]
            endcase
        end
        if (hw_standby)
        begin
            out_next = '0;
            oe_next = '0;
            pullup_next = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_pin_out <= '0;
            port_pin_oe <= '0;
            port_pin_pullup <= '0;
        end
        else
        begin
            port_pin_out <= out_next; // [R1]
            port_pin_oe <= oe_next;
            port_pin_pullup <= pullup_next;
        end
    end

    // read mux; direction register never reads back
    always_comb
    begin
        rdata_next = `UNDEF_READ_FILL;
        case (reg_addr)
            `ADDR_PIN_DIRECTION: rdata_next = `UNDEF_READ_FILL; // [R2]
            `ADDR_OUTPUT_VALUE: rdata_next[3:0] = output_value_reg; // [R8]
            `ADDR_PIN_LEVEL_READBACK: rdata_next[3:0] = readback_reg; // [R10]
            `ADDR_PULLUP_ENABLE: rdata_next[3:0] = pullup_enable_reg;
            `ADDR_OPENDRAIN_ENABLE: rdata_next[3:0] = opendrain_enable_reg;
            `ADDR_STANDBY_CONTROL:
            begin
                rdata_next[`STANDBY_OUTPUT_HOLD_BIT] = standby_output_hold_reg;
                rdata_next[`STANDBY_ENTER_BIT] = standby_enter_reg;
            end
            default: rdata_next = `UNDEF_READ_FILL;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_read)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= 8'h00;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sw_standby_active <= 1'b0;
        else
            sw_standby_active <= standby_enter_reg;
    end
endmodule : four_bit_io_port_addr_mux

/* File: pin_board.sv */
module pin_board
(
    // clock
    input wire logic sys_clk,
    // device drive
    input wire logic [3:0] port_pin_out,
    input wire logic [3:0] port_pin_oe,
    input wire logic [3:0] port_pin_pullup,
    // board drive
    input wire logic [3:0] ext_val,
    input wire logic [3:0] ext_en,
    output logic [3:0] port_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drift_reg = 4'h5;
    // undriven pin without pull-up wanders every cycle
    always @(posedge sys_clk)
        drift_reg <= ~drift_reg;
    always_comb
        for (int i = 0; i < 4; i++)
            port_pin_in[i] = port_pin_oe[i] ? port_pin_out[i] :
                ext_en[i] ? ext_val[i] : port_pin_pullup[i] | drift_reg[i];
endmodule : pin_board

/* File: four_bit_io_port_assertions.sv */
`include "port_io_defines.svh"
module port_io_checker
(
    // clock, reset
    input wire logic sys_clk,
    input wire logic rstn,
    // chip state
    input wire port_io_pkg::op_mode_t op_mode,
    input wire logic manual_reset,
    input wire logic hw_standby,
    input wire logic [3:0] address_out,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic [3:0] port_pin_out,
    input wire logic [3:0] port_pin_oe,
    input wire logic [3:0] port_pin_pullup,
    input wire logic sw_standby_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import port_io_pkg::*;
    logic [3:0] dir_sh, dat_sh, pu_sh, od_sh;
    logic calm;
    logic hw_ok;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // software view of the control registers
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            {dir_sh, dat_sh, pu_sh, od_sh} <= 16'h0000;
        else if (hw_standby)
            {dir_sh, dat_sh, pu_sh, od_sh} <= 16'h0000;
        else if (reg_write && !manual_reset)
            case (reg_addr)
                `ADDR_PIN_DIRECTION: dir_sh <= reg_wdata[3:0];
                `ADDR_OUTPUT_VALUE: dat_sh <= reg_wdata[3:0];
                `ADDR_PULLUP_ENABLE: pu_sh <= reg_wdata[3:0];
                `ADDR_OPENDRAIN_ENABLE: od_sh <= reg_wdata[3:0];
                default: ;
            endcase
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            hw_ok <= 1'b0;
        else
            hw_ok <= !hw_standby;
    // standby status and pins are launched at the same edge
    assign calm = hw_ok && !sw_standby_active;
    a_rdata_hi_zero: assert property (reg_rdata[7:4] == 4'h0)
        else $error("read data upper bits set");
    a_dir_unread: assert property ($past(reg_read) && $past(reg_addr) == `ADDR_PIN_DIRECTION
        |-> reg_rdata == 8'h00) else $error("direction readable");
    a_data_read: assert property ($past(reg_read) && $past(reg_addr) == `ADDR_OUTPUT_VALUE
        |-> reg_rdata == {4'h0, $past(dat_sh)}) else $error("output value read wrong");
    a_addr_all: assert property (calm && $past(op_mode) inside {mode_4, mode_5}
        |-> port_pin_oe == 4'hf && port_pin_out == $past(address_out) && port_pin_pullup == 4'h0)
        else $error("address pins wrong");
    a_addr_dir: assert property (calm && $past(op_mode) == mode_6 |-> port_pin_oe == $past(dir_sh)
        && ((port_pin_out ^ $past(address_out)) & $past(dir_sh)) == 4'h0) else $error("mode 6 wrong");
    a_gen_drive: assert property (calm && $past(op_mode) inside {mode_1, mode_2, mode_3, mode_7}
        |-> port_pin_oe == ($past(dir_sh) & ~($past(od_sh) & $past(dat_sh)))
        && ((port_pin_out ^ $past(dat_sh)) & port_pin_oe) == 4'h0) else $error("general drive wrong");
    a_pullup_gate: assert property (calm && $past(op_mode) inside {mode_1, mode_2, mode_3, mode_6, mode_7}
        |-> port_pin_pullup == ($past(pu_sh) & ~$past(dir_sh))) else $error("pull-up wrong");
    a_hw_release: assert property (hw_standby [*2] |-> port_pin_oe == 4'h0
        && port_pin_pullup == 4'h0) else $error("pins kept in hw standby");
    a_standby_pins: assert property (sw_standby_active && !$past(hw_standby)
        && $past(op_mode) inside {mode_4, mode_5} |-> port_pin_oe == 4'h0
        || (port_pin_oe == 4'hf && $stable(port_pin_out))) else $error("standby pins wrong");
    cover property (reg_write && reg_addr == `ADDR_PIN_LEVEL_READBACK);
    cover property (calm && op_mode == mode_6);
    cover property (hw_standby [*2]);
    cover property (sw_standby_active && port_pin_oe == 4'h0);
endmodule : port_io_checker
bind four_bit_io_port_addr_mux port_io_checker chk (.sys_clk, .rstn, .op_mode, .manual_reset,
    .hw_standby, .address_out, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .port_pin_out, .port_pin_oe, .port_pin_pullup, .sw_standby_active);

/* File: four_bit_io_port_addr_mux_tb_top.sv */
`include "port_io_defines.svh"
module four_bit_io_port_addr_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import port_io_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, manual_reset = 1'b0, hw_standby = 1'b0;
    op_mode_t op_mode = mode_1;
    logic [3:0] address_out = 4'h0, ext_val = 4'h0, ext_en = 4'h0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, seed = 8'h55;
    logic reg_write = 1'b0, reg_read = 1'b0, was_read = 1'b0;
    logic [3:0] port_pin_in, port_pin_out, port_pin_oe, port_pin_pullup;
    logic sw_standby_active;
    logic [7:0] exp_q[$];
    int miscompares = 0, check_count = 0, cycles = 0;

    four_bit_io_port_addr_mux dut (.sys_clk, .rstn, .op_mode, .manual_reset, .hw_standby,
        .address_out, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .port_pin_in,
        .port_pin_out, .port_pin_oe, .port_pin_pullup, .sw_standby_active);
    pin_board board (.sys_clk, .port_pin_out, .port_pin_oe, .port_pin_pullup, .ext_val,
        .ext_en, .port_pin_in);

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask : rd

    // read data stands in the cycle after the strobe
    always @(posedge sys_clk)
    begin
        if (was_read)
            check("reg_rdata", reg_rdata, exp_q.pop_front());
        was_read = reg_read;
        cycles++;
        if (cycles == 1500)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`ADDR_OUTPUT_VALUE, 8'h00);
        rd(`ADDR_PULLUP_ENABLE, 8'h00);
        rd(`ADDR_OPENDRAIN_ENABLE, 8'h00);
        wr(`ADDR_PIN_DIRECTION, 8'hff);
        rd(`ADDR_PIN_DIRECTION, 8'h00);
        rd(16'h1234, 8'h00);
        $display("done reset");
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            wr(`ADDR_OUTPUT_VALUE, seed);
            wr(`ADDR_PULLUP_ENABLE, ~seed);
            rd(`ADDR_OUTPUT_VALUE, {4'h0, seed[3:0]});
            rd(`ADDR_PULLUP_ENABLE, {4'h0, ~seed[3:0]});
        end
        $display("done regs");
        for (int m = 0; m < 8; m++)
        begin
            op_mode <= op_mode_t'(m[2:0]);
            for (int i = 0; i < 4; i++)
            begin
                seed = lfsr(seed);
                wr(`ADDR_PIN_DIRECTION, seed);
                wr(`ADDR_OPENDRAIN_ENABLE, {seed[3:0], seed[7:4]});
                address_out <= seed[7:4];
            end
        end
        $display("done modes");
        op_mode <= mode_1;
        wr(`ADDR_OPENDRAIN_ENABLE, 8'h00);
        wr(`ADDR_PULLUP_ENABLE, 8'h04);
        wr(`ADDR_OUTPUT_VALUE, 8'h0a);
        wr(`ADDR_PIN_DIRECTION, 8'h03);
        ext_en <= 4'h8;
        wr(`ADDR_PIN_LEVEL_READBACK, 8'hff);
        repeat (6) @(posedge sys_clk);
        rd(`ADDR_PIN_LEVEL_READBACK, 8'h06);
        manual_reset <= 1'b1;
        ext_val <= 4'h8;
        wr(`ADDR_OUTPUT_VALUE, 8'h05);
        repeat (6) @(posedge sys_clk);
        rd(`ADDR_PIN_LEVEL_READBACK, 8'h06);
        rd(`ADDR_OUTPUT_VALUE, 8'h0a);
        manual_reset <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(`ADDR_PIN_LEVEL_READBACK, 8'h0e);
        hw_standby <= 1'b1;
        repeat (3) @(posedge sys_clk);
        hw_standby <= 1'b0;
        rd(`ADDR_OUTPUT_VALUE, 8'h00);
        rd(`ADDR_PULLUP_ENABLE, 8'h00);
        $display("done pins");
        op_mode <= mode_4;
        address_out <= 4'h9;
        ext_en <= 4'hf;
        ext_val <= 4'h0;
        repeat (6) @(posedge sys_clk);
        wr(`ADDR_STANDBY_CONTROL, 8'h03);
        address_out <= 4'h6;
        repeat (2) @(posedge sys_clk);
        check("port_pin_out", {4'h0, port_pin_out}, 8'h09);
        check("port_pin_oe", {4'h0, port_pin_oe}, 8'h0f);
        check("sw_standby_active", {7'h0, sw_standby_active}, 8'h01);
        wr(`ADDR_STANDBY_CONTROL, 8'h02);
        repeat (6) @(posedge sys_clk);
        check("port_pin_oe", {4'h0, port_pin_oe}, 8'h00);
        rd(`ADDR_PIN_LEVEL_READBACK, 8'h09);
        wr(`ADDR_STANDBY_CONTROL, 8'h00);
        repeat (2) @(posedge sys_clk);
        check("port_pin_out", {4'h0, port_pin_out}, 8'h06);
        check("sw_standby_active", {7'h0, sw_standby_active}, 8'h00);
        $display("done standby");
        // let the last read data reach the monitor
        repeat (2) @(posedge sys_clk);
        if (exp_q.size() != 0)
            miscompares++;
        print_verdict();
    end
endmodule : four_bit_io_port_addr_mux_tb_top
